// ==== fnd_pkg.sv ====
package fnd_pkg;
  // serial word: data field above, register address in the low nibble
  localparam int WORD_W = 32;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 28;
  localparam int ADDR_LSB = 0;
  localparam int DATA_LSB = 4;
  localparam int FRAC_W = 22;
  localparam int INT_W = 12;

  localparam logic [3:0] ADDR_ZERO = 4'h0;
  localparam logic [3:0] ADDR_DENOM = 4'h1;
  localparam logic [3:0] ADDR_NUMER = 4'h2;
  localparam logic [3:0] ADDR_REF = 4'h3;
  localparam logic [3:0] ADDR_CAL = 4'h4;

  // register_zero fields
  localparam int INT_LSB = 0;
  localparam int ORDER_LSB = 12;
  localparam int DITHER_LSB = 14;
  // reference / output register fields
  localparam int REF_DIV_LSB = 0;
  localparam int REF_DIV_W = 8;
  localparam int DOUBLER_BIT = 8;
  localparam int OUT_DIV_LSB = 9;
  localparam int OUT_DIV_W = 5;
  localparam int BYPASS_BIT = 14;
  localparam int REFERENCE_FREQUENCY_SETTING_LSB = 15;
  localparam int REFERENCE_FREQUENCY_SETTING_W = 8;
  // calibration start register fields
  localparam int CORE_LSB = 0;
  localparam int CORE_W = 2;
  localparam int CAP_LSB = 2;
  localparam int CAP_W = 8;

  localparam logic [11:0] INT_RST = 12'h010;
  localparam logic [7:0] REF_DIV_RST = 8'h01;
  localparam logic [4:0] OUT_DIV_RST = 5'h01;
  localparam logic [7:0] REFERENCE_FREQUENCY_SETTING_RST = 8'h00;
  localparam logic [1:0] CORE_RST = 2'h0;
  localparam logic [7:0] CAP_RST = 8'h00;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  // below this modulus the dither could push a stage two moduli past its residue
  localparam int DITHER_MIN_DEN = 4;

  typedef enum logic [1:0] {ORD_INT, ORD_FIRST, ORD_SECOND, ORD_THIRD} fnd_order_t;
  typedef enum logic [1:0] {DITH_OFF, DITH_WEAK, DITH_STRONG, DITH_RSVD} fnd_dither_t;
endpackage

// ==== fnd_acc_if.sv ====
`timescale 1ns/1ns
interface fnd_acc_if #(parameter int W = 22);
  logic [W-1:0] modulus;
  logic clear;
  logic [W+1:0] addend;
  logic [W-1:0] residue;
  logic carry;
  modport stage(input modulus, input clear, input addend, output residue, output carry);
  modport ctrl(output modulus, output clear, output addend, input residue, input carry);
endinterface

// ==== fnd_accum.sv ====
`timescale 1ns/1ns
module fnd_accum #(
  parameter int W = 22
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  fnd_acc_if.stage acc
);
  logic [W-1:0] residue;
  logic carry;
  logic [W+1:0] sum;
  logic [W-1:0] next_residue;
  logic next_carry;

  // modulo-modulus accumulator: exact for any modulus, not only powers of two
  always_comb
  begin
    sum = {2'b00, residue} + acc.addend;
    next_residue = sum[W-1:0];
    next_carry = 1'b0;
    if (acc.clear)
    begin
      next_residue = '0;
    end
    else if (sum >= {2'b00, acc.modulus})
    begin
      next_residue = W'(sum - {2'b00, acc.modulus});
      next_carry = 1'b1;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      residue <= '0;
      carry <= 1'b0;
    end
    else
    begin
      residue <= next_residue;
      carry <= next_carry;
    end
  end

  assign acc.residue = residue;
  assign acc.carry = carry;

  a_residue_bound: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (!acc.clear && residue < acc.modulus && acc.addend < {2'b00, acc.modulus})
    |=> residue < $past(acc.modulus))
    else $error("accumulator residue left its modulus");
endmodule // fnd_accum

// ==== fnd_ctrl.sv ====
`timescale 1ns/1ns
// How it works
// - output frequency follows doubler, reference divide, feedback ratio and output divide.
// - reference passes optional doubler, then reference divider, to the detector.
// - doubler and reference divider may be enabled together.
// - denominator takes 1 to 4194303, realised exactly by modulo accumulation.
// - feedback ratio is integer plus numerator over denominator, all writable.
// - modulator order selects integer, first, second or third order.
// - dithering is selectable, including off.
// - each write to register_zero resets the modulator state.
// - software picks calibration start core and capacitor code.
// - output divider can be bypassed.
module fnd_ctrl
  import fnd_pkg::*;
#(
  parameter int FRAC_BITS = FRAC_W
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_sclk,
  input wire logic i_sdata,
  input wire logic i_sle,
  output logic [INT_W-1:0] o_int_value,
  output logic [FRAC_BITS-1:0] o_fraction_numerator,
  output logic [FRAC_BITS-1:0] o_fraction_denominator,
  output logic [INT_W:0] o_n_div,
  output logic [1:0] o_mod_order,
  output logic [1:0] o_dither_mode,
  output logic o_reference_doubler_enable,
  output logic [REF_DIV_W-1:0] o_ref_divide,
  output logic [OUT_DIV_W-1:0] o_output_divide_value,
  output logic o_output_bypass,
  output logic [REFERENCE_FREQUENCY_SETTING_W-1:0] o_reference_frequency_setting,
  output logic [CORE_W-1:0] o_calibration_start_core,
  output logic [CAP_W-1:0] o_calibration_start_capacitor_code,
  output logic o_cal_start,
  output logic o_mod_reset
);
  generate
    if (FRAC_BITS < 3 || FRAC_BITS > DATA_W)
    begin : g_bad_width
      $error("FRAC_BITS must lie between 3 and the serial data width");
    end
  endgenerate

  // link side: shifts only while enable is low, so the word is still while it is high
  logic [WORD_W-1:0] shift_word;
  logic [WORD_W-1:0] next_shift_word;

  always_comb
  begin
    next_shift_word = shift_word;
    if (!i_sle)
    begin
      next_shift_word = {shift_word[WORD_W-2:0], i_sdata};
    end
  end

  always_ff @(posedge i_sclk)
  begin
    shift_word <= next_shift_word;
  end

  // enable crosses as a level; its rise qualifies the held word
  logic le_s1;
  logic le_s2;
  logic le_s3;
  logic wr_stb;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      le_s1 <= 1'b1;
      le_s2 <= 1'b1;
      le_s3 <= 1'b1;
    end
    else
    begin
      le_s1 <= i_sle;
      le_s2 <= le_s1;
      le_s3 <= le_s2;
    end
  end

  assign wr_stb = le_s2 & ~le_s3;
  assign wr_addr = shift_word[ADDR_LSB +: ADDR_W];
  assign wr_data = shift_word[DATA_LSB +: DATA_W];

  // configuration registers; these flops are the outputs themselves
  logic [INT_W-1:0] next_int_value;
  logic [FRAC_BITS-1:0] next_numerator;
  logic [FRAC_BITS-1:0] next_denominator;
  logic [1:0] next_order;
  logic [1:0] next_dither;
  logic next_doubler;
  logic [REF_DIV_W-1:0] next_ref_divide;
  logic [OUT_DIV_W-1:0] next_out_divide;
  logic next_bypass;
  logic [REFERENCE_FREQUENCY_SETTING_W-1:0] next_reference_frequency_setting;
  logic [CORE_W-1:0] next_core;
  logic [CAP_W-1:0] next_cap;
  logic next_cal_start;
  logic next_mod_reset;

  always_comb
  begin
    next_int_value = o_int_value;
    next_numerator = o_fraction_numerator;
    next_denominator = o_fraction_denominator;
    next_order = o_mod_order;
    next_dither = o_dither_mode;
    next_doubler = o_reference_doubler_enable;
    next_ref_divide = o_ref_divide;
    next_out_divide = o_output_divide_value;
    next_bypass = o_output_bypass;
    next_reference_frequency_setting = o_reference_frequency_setting;
    next_core = o_calibration_start_core;
    next_cap = o_calibration_start_capacitor_code;
    next_cal_start = 1'b0;
    // a new fraction also restarts the modulator so no residue outgrows its modulus
    next_mod_reset = wr_stb && (wr_addr == ADDR_ZERO || wr_addr == ADDR_DENOM
      || wr_addr == ADDR_NUMER);
    if (wr_stb)
    begin
      case (wr_addr)
        ADDR_ZERO:
        begin
          next_int_value = wr_data[INT_LSB +: INT_W];
          next_order = wr_data[ORDER_LSB +: 2];
          next_dither = wr_data[DITHER_LSB +: 2];
          next_cal_start = 1'b1;
        end
        ADDR_DENOM:
        begin
          // a zero denominator is refused and the old one kept
          if (wr_data[FRAC_BITS-1:0] != '0)
          begin
            next_denominator = wr_data[FRAC_BITS-1:0];
          end
        end
        ADDR_NUMER: next_numerator = wr_data[FRAC_BITS-1:0];
        ADDR_REF:
        begin
          next_ref_divide = wr_data[REF_DIV_LSB +: REF_DIV_W];
          next_doubler = wr_data[DOUBLER_BIT];
          next_out_divide = wr_data[OUT_DIV_LSB +: OUT_DIV_W];
          next_bypass = wr_data[BYPASS_BIT];
          next_reference_frequency_setting = wr_data[REFERENCE_FREQUENCY_SETTING_LSB +: REFERENCE_FREQUENCY_SETTING_W];
        end
        ADDR_CAL:
        begin
          next_core = wr_data[CORE_LSB +: CORE_W];
          next_cap = wr_data[CAP_LSB +: CAP_W];
        end
        default: next_cal_start = 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      o_int_value <= INT_RST;
      o_fraction_numerator <= '0;
      o_fraction_denominator <= FRAC_BITS'(1);
      o_mod_order <= ORD_INT;
      o_dither_mode <= DITH_OFF;
      o_reference_doubler_enable <= 1'b0;
      o_ref_divide <= REF_DIV_RST;
      o_output_divide_value <= OUT_DIV_RST;
      o_output_bypass <= 1'b1;
      o_reference_frequency_setting <= REFERENCE_FREQUENCY_SETTING_RST;
      o_calibration_start_core <= CORE_RST;
      o_calibration_start_capacitor_code <= CAP_RST;
      o_cal_start <= 1'b0;
      o_mod_reset <= 1'b0;
    end
    else
    begin
      o_int_value <= next_int_value;
      o_fraction_numerator <= next_numerator;
      o_fraction_denominator <= next_denominator;
      o_mod_order <= next_order;
      o_dither_mode <= next_dither;
      o_reference_doubler_enable <= next_doubler;
      o_ref_divide <= next_ref_divide;
      o_output_divide_value <= next_out_divide;
      o_output_bypass <= next_bypass;
      o_reference_frequency_setting <= next_reference_frequency_setting;
      o_calibration_start_core <= next_core;
      o_calibration_start_capacitor_code <= next_cap;
      o_cal_start <= next_cal_start;
      o_mod_reset <= next_mod_reset;
    end
  end

  // cascaded modulator: three modulo accumulators, error of one feeds the next
  fnd_acc_if #(.W(FRAC_BITS)) stg[3] ();

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_stage
      fnd_accum #(.W(FRAC_BITS)) u_accum (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .acc(stg[gi])
      );
    end
  endgenerate

  logic [15:0] lfsr;
  logic [15:0] next_lfsr;
  logic [FRAC_BITS+1:0] dither_val;
  logic [5:0] cdly;
  logic [5:0] next_cdly;
  logic signed [3:0] frac;
  logic [INT_W:0] next_n_div;

  // dither enters stage two only; its carry is differenced, so the mean ratio stays exact
  always_comb
  begin
    dither_val = '0;
    if (o_fraction_denominator >= FRAC_BITS'(DITHER_MIN_DEN))
    begin
      case (o_dither_mode)
        DITH_WEAK: dither_val = {{(FRAC_BITS+1){1'b0}}, lfsr[0]};
        DITH_STRONG: dither_val = {{FRAC_BITS{1'b0}}, lfsr[1:0]};
        default: dither_val = '0;
      endcase
    end
  end

  assign stg[0].modulus = o_fraction_denominator;
  assign stg[1].modulus = o_fraction_denominator;
  assign stg[2].modulus = o_fraction_denominator;
  assign stg[0].clear = o_mod_reset;
  assign stg[1].clear = o_mod_reset;
  assign stg[2].clear = o_mod_reset;
  assign stg[0].addend = {2'b00, o_fraction_numerator};
  assign stg[1].addend = {2'b00, stg[0].residue} + dither_val;
  assign stg[2].addend = {2'b00, stg[1].residue};

  // delays line the three carries up on the same input sample
  always_comb
  begin
    next_lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    next_cdly = {cdly[4], stg[2].carry, cdly[2], stg[1].carry, cdly[0], stg[0].carry};
    if (o_mod_reset)
    begin
      next_lfsr = LFSR_SEED;
      next_cdly = '0;
    end
    // during the restart pulse the old carries are dropped, so the divide sequence repeats
    case (o_mod_reset ? ORD_INT : fnd_order_t'(o_mod_order))
      ORD_INT: frac = 4'sd0;
      ORD_FIRST: frac = $signed({3'b000, stg[0].carry});
      ORD_SECOND: frac = $signed({3'b000, cdly[1]}) + $signed({3'b000, cdly[2]})
        - $signed({3'b000, cdly[3]});
      ORD_THIRD: frac = $signed({3'b000, cdly[1]}) + $signed({3'b000, cdly[2]})
        - $signed({3'b000, cdly[3]}) + $signed({3'b000, stg[2].carry})
        - $signed({2'b00, cdly[4], 1'b0}) + $signed({3'b000, cdly[5]});
      default: frac = 4'sd0;
    endcase
    // instantaneous feedback divide; its average is integer plus the fraction
    next_n_div = {1'b0, o_int_value} + {{(INT_W-3){frac[3]}}, frac};
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      lfsr <= LFSR_SEED;
      cdly <= '0;
      o_n_div <= '0;
    end
    else
    begin
      lfsr <= next_lfsr;
      cdly <= next_cdly;
      o_n_div <= next_n_div;
    end
  end

  // checks, all in the main clock domain
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  logic [DATA_W-1:0] last_data;
  always_ff @(posedge i_mclk)
  begin
    last_data <= wr_data;
  end
  sequence seq_le_rise;
    !le_s2 ##1 le_s2;
  endsequence
  sequence seq_zero_write;
    wr_stb && wr_addr == ADDR_ZERO;
  endsequence
  sequence seq_mod_cleared;
    o_mod_reset ##1 (stg[0].residue == '0 && stg[1].residue == '0 && stg[2].residue == '0);
  endsequence
  a_word_transfer: assert property (seq_le_rise |-> wr_stb ##1 !wr_stb)
    else $error("enable rise did not give one load strobe");
  a_zero_resets_mod: assert property (seq_zero_write |=> seq_mod_cleared)
    else $error("register_zero write did not clear the modulator");
  a_cal_start_pulse: assert property (seq_zero_write |=> o_cal_start ##1 !o_cal_start)
    else $error("calibration start is not a single pulse");
  a_cal_code_load: assert property (wr_stb && wr_addr == ADDR_CAL
    |=> o_calibration_start_capacitor_code == last_data[CAP_LSB +: CAP_W]
      && o_calibration_start_core == last_data[CORE_LSB +: CORE_W])
    else $error("calibration start codes not loaded");
  a_ref_path_load: assert property (wr_stb && wr_addr == ADDR_REF
    |=> o_reference_doubler_enable == last_data[DOUBLER_BIT]
      && o_ref_divide == last_data[REF_DIV_LSB +: REF_DIV_W])
    else $error("doubler and reference divide not loaded together");
  a_bypass_load: assert property (wr_stb && wr_addr == ADDR_REF
    |=> o_output_bypass == last_data[BYPASS_BIT])
    else $error("output bypass not loaded");
  a_den_nonzero: assert property (o_fraction_denominator != '0)
    else $error("denominator reached zero");
  a_int_mode: assert property (o_mod_order == ORD_INT
    |=> o_n_div == {1'b0, $past(o_int_value)})
    else $error("integer mode divide differs from integer value");
  a_first_span: assert property (o_mod_order == ORD_FIRST
    |=> o_n_div == {1'b0, $past(o_int_value)} || o_n_div == {1'b0, $past(o_int_value)} + 1'b1)
    else $error("first order divide outside integer and integer plus one");
  a_dither_off: assert property (o_dither_mode == DITH_OFF
    |-> stg[1].addend == {2'b00, stg[0].residue})
    else $error("dither applied while off");
endmodule // fnd_ctrl

// ==== fnd_host_model.sv ====
`timescale 1ns/1ns
module fnd_host_model (
  output logic o_sclk,
  output logic o_sdata,
  output logic o_sle
);
  initial
  begin
    o_sclk = 1'b0;
    o_sdata = 1'b0;
    o_sle = 1'b1;
  end

  // the link clock runs only inside a frame, 12 ns period, then stands low
  task automatic write_word(input logic [31:0] w);
    #3 o_sle = 1'b0;
    #7;
    for (int b = 31; b >= 0; b--)
    begin
      o_sdata = w[b];
      #6 o_sclk = 1'b1;
      #6 o_sclk = 1'b0;
    end
    #6 o_sle = 1'b1;
    // data released: show the inverse so a late sample cannot pass by luck
    o_sdata = ~w[0];
    // enable held high well past the synchroniser, no clock edge meanwhile
    #400;
  endtask
endmodule // fnd_host_model

// ==== test_fractional_n_divider_control.sv ====
`timescale 1ns/1ns
module test_fractional_n_divider_control;
  import fnd_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic sclk, sdata, sle;
  logic [INT_W-1:0] o_int_value;
  logic [FRAC_W-1:0] o_fraction_numerator, o_fraction_denominator;
  logic [INT_W:0] o_n_div;
  logic [1:0] o_mod_order, o_dither_mode;
  logic o_reference_doubler_enable, o_output_bypass, o_cal_start, o_mod_reset;
  logic [REF_DIV_W-1:0] o_ref_divide;
  logic [OUT_DIV_W-1:0] o_output_divide_value;
  logic [REFERENCE_FREQUENCY_SETTING_W-1:0] o_reference_frequency_setting;
  logic [CORE_W-1:0] o_calibration_start_core;
  logic [CAP_W-1:0] o_calibration_start_capacitor_code;
  int error_cnt = 0;
  int checks = 0;
  int since_rst = 0;
  int cal_cnt = 0;
  int mr_cnt = 0;
  logic [31:0] seed = 32'h55;
  logic [INT_W:0] seq [32];

  always #25 i_mclk = ~i_mclk;

  fnd_host_model i_fnd_host_model (.o_sclk(sclk), .o_sdata(sdata), .o_sle(sle));

  fnd_ctrl i_fnd_ctrl (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_sclk(sclk),
    .i_sdata(sdata),
    .i_sle(sle),
    .o_int_value(o_int_value),
    .o_fraction_numerator(o_fraction_numerator),
    .o_fraction_denominator(o_fraction_denominator),
    .o_n_div(o_n_div),
    .o_mod_order(o_mod_order),
    .o_dither_mode(o_dither_mode),
    .o_reference_doubler_enable(o_reference_doubler_enable),
    .o_ref_divide(o_ref_divide),
    .o_output_divide_value(o_output_divide_value),
    .o_output_bypass(o_output_bypass),
    .o_reference_frequency_setting(o_reference_frequency_setting),
    .o_calibration_start_core(o_calibration_start_core),
    .o_calibration_start_capacitor_code(o_calibration_start_capacitor_code),
    .o_cal_start(o_cal_start),
    .o_mod_reset(o_mod_reset)
  );

  // pulses counted per cycle, so a pulse two cycles long counts twice
  always @(negedge i_mclk)
  begin
    if (o_cal_start === 1'b1) cal_cnt++;
    if (o_mod_reset === 1'b1)
    begin
      mr_cnt++;
      since_rst = 0;
    end
    else since_rst++;
    if (since_rst < 32) seq[since_rst] = o_n_div;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [27:0] d);
    @(negedge i_mclk);
    i_fnd_host_model.write_word({d, a});
  endtask

  task automatic wait_rst(input int n);
    int k;
    k = 0;
    while (since_rst < n && k < 100)
    begin
      @(negedge i_mclk);
      k++;
    end
  endtask

  task automatic run_mode(input int ord, input int dith);
    logic [31:0] r;
    logic [11:0] iv;
    logic [21:0] den, num;
    logic signed [31:0] sum, d, lo, hi, tol, exp_sum;
    logic ok;
    int w, m, c;
    r = rnd();
    den = 22'(5 + r % 20);
    num = 22'(1 + (r >> 8) % (den - 1));
    iv = 12'(16 + (r >> 16) % 4000);
    w = den * 20;
    m = mr_cnt;
    c = cal_cnt;
    wr(ADDR_DENOM, {6'h00, den});
    wr(ADDR_NUMER, {6'h00, num});
    wr(ADDR_ZERO, {12'h000, 2'(dith), 2'(ord), iv});
    check(mr_cnt - m, 3, "modulator resets");
    check(cal_cnt - c, 1, "calibration starts");
    check({o_mod_order, o_dither_mode}, {2'(ord), 2'(dith)}, "mode");
    check({o_int_value, o_fraction_numerator, o_fraction_denominator},
      {iv, num, den}, "fraction regs");
    wait_rst(8);
    lo = (ord == 3) ? -3 : (ord == 2) ? -1 : 0;
    hi = (ord == 3) ? 4 : (ord == 2) ? 2 : ord;
    tol = (ord >= 2) ? 8 : (ord == 1) ? 1 : 0;
    exp_sum = iv * w + ((ord == 0) ? 0 : num * 20);
    sum = 0;
    ok = 1'b1;
    repeat (w)
    begin
      @(negedge i_mclk);
      d = 32'(o_n_div) - 32'(iv);
      sum = sum + 32'(o_n_div);
      ok = ok & (d >= lo) & (d <= hi);
    end
    check(ok, 1'b1, "step range");
    check((sum - exp_sum <= tol) & (exp_sum - sum <= tol), 1'b1, "mean ratio");
  endtask

  initial
  begin
    logic [31:0] r;
    logic [INT_W:0] first [32];
    int m, c, diffs;
    i_rst_n = 1'b0;
    repeat (4) @(negedge i_mclk);
    i_rst_n = 1'b1;
    repeat (4) @(negedge i_mclk);
    check(o_int_value, INT_RST, "int reset");
    check({o_fraction_numerator, o_fraction_denominator}, 44'h1, "fraction reset");
    check({o_mod_order, o_dither_mode, o_cal_start, o_mod_reset}, 6'h00, "mode reset");
    check({o_reference_doubler_enable, o_ref_divide, o_output_divide_value, o_output_bypass},
      {1'b0, REF_DIV_RST, OUT_DIV_RST, 1'b1}, "ref reset");
    check({o_reference_frequency_setting, o_calibration_start_core,
      o_calibration_start_capacitor_code}, {REFERENCE_FREQUENCY_SETTING_RST, CORE_RST, CAP_RST}, "cal reset");
    check(o_n_div, {1'b0, INT_RST}, "divide reset");
    for (int i = 0; i < 3; i++)
    begin
      m = mr_cnt;
      c = cal_cnt;
      r = rnd();
      r[8] = (i == 0);
      r[14] = i[0];
      wr(ADDR_REF, r[27:0]);
      check({o_reference_doubler_enable, o_ref_divide}, r[8:0], "ref path");
      check({o_output_bypass, o_output_divide_value}, r[14:9], "out divide");
      check(o_reference_frequency_setting, r[22:15], "osc setting");
      check(mr_cnt - m + cal_cnt - c, 0, "no pulse");
    end
    for (int i = 0; i < 2; i++)
    begin
      r = (i == 0) ? {22'h0, 8'h7F, 2'h2} : {22'h0, 8'h0F, 2'h3};
      wr(ADDR_CAL, r[27:0]);
      check({o_calibration_start_capacitor_code, o_calibration_start_core}, r[9:0],
        "cal start");
    end
    wr(ADDR_DENOM, 28'h0000001);
    check(o_fraction_denominator, 22'h000001, "den min");
    wr(ADDR_DENOM, 28'h03FFFFF);
    check(o_fraction_denominator, 22'h3FFFFF, "den max");
    wr(ADDR_DENOM, 28'h0000000);
    check(o_fraction_denominator, 22'h3FFFFF, "den zero kept");
    wr(4'h5, 28'hFFFFFFF);
    check({o_int_value, o_fraction_denominator}, {INT_RST, 22'h3FFFFF}, "addr ignored");
    for (int o = 0; o < 4; o++)
      for (int t = 0; t < 4; t++)
        run_mode(o, t);
    // same setting twice must give the same divide sequence
    wr(ADDR_ZERO, {12'h000, 2'(DITH_STRONG), 2'(ORD_THIRD), 12'h123});
    wait_rst(32);
    first = seq;
    wr(ADDR_ZERO, {12'h000, 2'(DITH_STRONG), 2'(ORD_THIRD), 12'h123});
    wait_rst(32);
    diffs = 0;
    for (int i = 1; i < 32; i++)
      if (seq[i] !== first[i]) diffs++;
    check(diffs, 0, "repeatable sequence");
    end_of_test();
  end

  // sixteen mode runs of at most 480 cycles plus writes stay far below 3 ms
  initial
  begin
    #3000000;
    error_cnt++;
    end_of_test();
  end
endmodule // test_fractional_n_divider_control
